// ===== verilog/nand_seq_params.svh
`ifndef NAND_SEQ_PARAMS_SVH
`define NAND_SEQ_PARAMS_SVH
// ****************************************
// command codes
// ****************************************
`define CMD_SER_IN 8'h80
`define CMD_SECOND 8'h81
`define CMD_COL_CHG 8'h85
`define CMD_PROG 8'h10
`define CMD_FIRST_END 8'h11
`define CMD_ERASE_SET 8'h60
`define CMD_ERASE_GO 8'hD0
`define CMD_READ_SET 8'h00
`define CMD_READ_CB 8'h35
`define CMD_STAT 8'h70
`define CMD_STAT_DIST 8'h71
`define CMD_RESET 8'hFF
// ****************************************
// page layout
// ****************************************
`define PAGE_BYTES 13'h1080
`define SPARE_BASE 13'h1000
`define PARITY_BASE 13'h1080
`define BUF_BYTES 4352
`define MAIN_LAST 10'h1FF
`define SPARE_LAST 10'h20F
`define WALK_LAST 10'h21F
`define DIST_BIT 6
// ****************************************
// register offsets and reset values
// ****************************************
`define REG_PROG_TIME 12'h000
`define REG_ERASE_TIME 12'h004
`define REG_FAIL_INJ 12'h008
`define REG_STATUS 12'h00C
`define PROG_TIME_RST 16'h0100
`define ERASE_TIME_RST 16'h0400
`endif

// ===== verilog/nand_seq_pkg.sv
package nand_seq_pkg;
  typedef enum logic [2:0] {
    st_idle, st_load, st_wait_second, st_erase_addr, st_read_addr, st_busy
  } seq_state_t;
  typedef enum logic [1:0] {op_prog, op_erase, op_read} op_t;
  typedef enum logic [1:0] {stat_none, stat_70, stat_71} stat_mode_t;
endpackage

// ===== verilog/ecc_if.sv
interface ecc_if;
  logic clear;
  logic valid;
  logic [7:0] data;
  logic [127:0] parity;
  modport src (output clear, output valid, output data, input parity);
  modport eng (input clear, input valid, input data, output parity);
endinterface

// ===== verilog/pin_sync.sv
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins in, synchronised out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1)
  begin : g_chk
    $error("pin_sync needs WIDTH of at least 1");
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= RST;
      q <= RST;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// ===== verilog/ecc_parity.sv
module ecc_parity #(
  parameter int PAR_BITS = 128
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // byte stream in, sector parity out
  ecc_if.eng bus
);
  logic [PAR_BITS-1:0] sig_q;
  logic [PAR_BITS-1:0] base;
  logic [7:0] fold;

  if (PAR_BITS != 128)
  begin : g_chk
    $error("ecc_parity supports a 128-bit parity field only");
  end

  // restart on the first byte of each sector
  assign base = bus.clear ? '0 : sig_q;
  assign fold = base[PAR_BITS-1 -: 8] ^ bus.data;
  assign bus.parity = sig_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sig_q <= '0;
    else if (bus.valid)
      sig_q <= {base[PAR_BITS-9:0], fold} ^ {fold, 56'h0, fold, 56'h0};
  end
endmodule

// ===== verilog/nand_seq.sv
// Contract
// - parity per 528-byte codeword made while busy; read detects errors per codeword.
// - codeword is 512 main bytes plus 16 spare bytes; checked on every read.
// - sector n uses main 512(n-1).. and spare 4096+16(n-1)..
// - parity lives in columns 4224-4351, closed to host reads and writes.
// - 70h reports read ECC result, held until another valid command; the code clears it only on 80h, 00h, 60h, FFh or the next busy start.
// - 10h after setup, address and data starts page program.
// - 85h plus two address cycles sets a new column, repeatable.
// - dual program: page closed by 11h, second opened by 81h, 10h.
// - after dual program, 70h fail bit is OR of both pages.
// - 71h byte: OR, district fails, ready bits, not-protected bit.
// - even blocks district 0, odd blocks district 1.
// - D0h after 60h and block address starts erase.
// - two 60h addresses then D0h erase both, results via 71h.
// - 35h read runs the ECC check over the page buffer; no page data is loaded.
// - copy-back opened by 85h with address, programs on 10h.
// - copy-back shows busy on pin and bit 6, stays in status mode.
// - address is two column bytes then three row bytes.
`include "nand_seq_params.svh"
module nand_seq #(
  parameter int TIME_W = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // flash pins
  input wire logic cle,
  input wire logic ale,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic read_strobe_n,
  input wire logic wp_n,
  input wire logic [7:0] io_in,
  output logic [7:0] io_out,
  output logic io_oe,
  output logic ready_busy_n
);
  if (TIME_W < 1 || TIME_W > 16)
  begin : g_chk
    $error("TIME_W must be 1 to 16");
  end

  // ****************************************
  // pin synchronisers and strobe decode
  // ****************************************
  logic [13:0] pins_s;
  logic cle_s, ale_s, ce_n_s, we_n_s, re_n_s, wp_n_s;
  logic [7:0] io_s;
  logic we_n_prev_q;
  pin_sync #(.WIDTH(14), .RST(14'h0E00)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({cle, ale, ce_n, we_n, read_strobe_n, wp_n, io_in}),
    .q(pins_s)
  );
  assign {cle_s, ale_s, ce_n_s, we_n_s, re_n_s, wp_n_s, io_s} = pins_s;

  wire we_rise = we_n_s & ~we_n_prev_q & ~ce_n_s;
  wire cmd_lat = we_rise & cle_s & ~ale_s;
  wire adr_lat = we_rise & ale_s & ~cle_s;
  wire dat_lat = we_rise & ~ale_s & ~cle_s;

  // ****************************************
  // sequencer state
  // ****************************************
  nand_seq_pkg::seq_state_t state_q, state_d;
  nand_seq_pkg::op_t op_q;
  nand_seq_pkg::stat_mode_t stat_q;
  logic [2:0] addr_left_q, addr_idx_q;
  logic [12:0] col_q, col_d;
  logic [16:0] row_q, row_d;
  logic [1:0] dist_used_q, fail_q;
  logic ecc_fail_q, ecc_err_q, read_res_q, cb_ready_q;
  logic [TIME_W-1:0] timer_q, prog_time_q, erase_time_q;
  logic [1:0] fail_inj_q;
  logic walk_on_q;
  logic [2:0] walk_sec_q;
  logic [9:0] walk_idx_q;
  logic [7:0] buf_mem [0:`BUF_BYTES-1];

  wire busy = state_q == nand_seq_pkg::st_busy;
  wire addr_done = addr_left_q == 3'h0;
  wire is_reset = cmd_lat & io_s == `CMD_RESET;
  wire start_prog = cmd_lat & io_s == `CMD_PROG & addr_done
    & state_q == nand_seq_pkg::st_load;
  wire start_erase = cmd_lat & io_s == `CMD_ERASE_GO & addr_done & |dist_used_q
    & state_q == nand_seq_pkg::st_erase_addr;
  wire start_read = cmd_lat & io_s == `CMD_READ_CB & addr_done
    & state_q == nand_seq_pkg::st_read_addr;
  wire go_busy = ((start_prog | start_erase) & wp_n_s) | start_read;
  wire inhibit = (start_prog | start_erase) & ~wp_n_s;
  wire done = busy & timer_q == '0 & ~walk_on_q;
  wire new_op = cmd_lat & ~busy & (io_s == `CMD_SER_IN | io_s == `CMD_READ_SET
    | (io_s == `CMD_ERASE_SET & state_q != nand_seq_pkg::st_erase_addr));
  wire cb_open = cmd_lat & io_s == `CMD_COL_CHG & cb_ready_q
    & state_q == nand_seq_pkg::st_idle;
  wire col_chg = cmd_lat & io_s == `CMD_COL_CHG
    & state_q == nand_seq_pkg::st_load;
  wire adr_take = adr_lat & ~addr_done & ~busy;
  wire dat_take = dat_lat & addr_done & state_q == nand_seq_pkg::st_load;
  wire host_wr = dat_take & col_q < `PAGE_BYTES;

  always_comb
  begin
    state_d = state_q;
    if (is_reset)
      state_d = nand_seq_pkg::st_idle;
    else if (busy)
    begin
      if (done)
        state_d = nand_seq_pkg::st_idle;
    end
    else if (go_busy)
      state_d = nand_seq_pkg::st_busy;
    else if (inhibit)
      state_d = nand_seq_pkg::st_idle;
    else if (cmd_lat)
    begin
      unique case (io_s)
        `CMD_SER_IN: state_d = nand_seq_pkg::st_load;
        `CMD_SECOND:
          if (state_q == nand_seq_pkg::st_wait_second)
            state_d = nand_seq_pkg::st_load;
        `CMD_COL_CHG:
          if (cb_open)
            state_d = nand_seq_pkg::st_load;
        `CMD_FIRST_END:
          if (state_q == nand_seq_pkg::st_load && addr_done)
            state_d = nand_seq_pkg::st_wait_second;
        `CMD_ERASE_SET: state_d = nand_seq_pkg::st_erase_addr;
        `CMD_READ_SET: state_d = nand_seq_pkg::st_read_addr;
        `CMD_STAT, `CMD_STAT_DIST: state_d = state_q;
        default: state_d = nand_seq_pkg::st_idle;
      endcase
    end
  end

  // ****************************************
  // address cycles
  // ****************************************
  wire [2:0] left_load = (io_s == `CMD_ERASE_SET) ? 3'h3 : col_chg ? 3'h2 : 3'h5;
  wire [2:0] idx_load = (io_s == `CMD_ERASE_SET) ? 3'h2 : 3'h0;
  wire addr_open = cmd_lat & ~busy & (io_s == `CMD_SER_IN | col_chg | cb_open
    | io_s == `CMD_ERASE_SET | io_s == `CMD_READ_SET
    | (io_s == `CMD_SECOND & state_q == nand_seq_pkg::st_wait_second));
  wire row_end = adr_take & addr_idx_q == 3'h4;

  // column bytes then three row bytes
  assign col_d = (adr_take && addr_idx_q == 3'h0) ? {col_q[12:8], io_s}
    : (adr_take && addr_idx_q == 3'h1) ? {io_s[4:0], col_q[7:0]}
    : dat_take ? col_q + 13'h1 : col_q;
  assign row_d = (adr_take && addr_idx_q == 3'h2) ? {row_q[16:8], io_s}
    : (adr_take && addr_idx_q == 3'h3) ? {row_q[16], io_s, row_q[7:0]}
    : row_end ? {io_s[0], row_q[15:0]} : row_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= nand_seq_pkg::st_idle;
      addr_left_q <= 3'h0;
      addr_idx_q <= 3'h0;
      col_q <= 13'h0;
      row_q <= 17'h0;
      we_n_prev_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      col_q <= col_d;
      row_q <= row_d;
      we_n_prev_q <= we_n_s;
      if (is_reset)
        addr_left_q <= 3'h0;
      else if (addr_open)
      begin
        addr_left_q <= left_load;
        addr_idx_q <= idx_load;
      end
      else if (adr_take)
      begin
        addr_left_q <= addr_left_q - 3'h1;
        addr_idx_q <= addr_idx_q + 3'h1;
      end
    end
  end

  // districts touched by this operation
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dist_used_q <= 2'h0;
    else if (is_reset || (new_op && io_s != `CMD_ERASE_SET) || cb_open)
      dist_used_q <= 2'h0;
    else if (new_op)
      dist_used_q <= 2'h0;
    else if (row_end)
      dist_used_q[row_q[`DIST_BIT]] <= 1'b1;
  end

  // ****************************************
  // ecc walk over the page buffer
  // ****************************************
  ecc_if ecc ();
  ecc_parity #(.PAR_BITS(128)) u_ecc (
    .pclk(pclk),
    .presetn(presetn),
    .bus(ecc.eng)
  );

  wire walk_main = walk_idx_q <= `MAIN_LAST;
  wire walk_data = walk_idx_q <= `SPARE_LAST;
  wire walk_end = walk_on_q & walk_sec_q == 3'h7 & walk_idx_q == `WALK_LAST;
  wire [12:0] sec_off = {6'h0, walk_sec_q, 4'h0};
  wire [12:0] walk_col = walk_main ? {1'b0, walk_sec_q, walk_idx_q[8:0]}
    : walk_data ? `SPARE_BASE + sec_off + {9'h0, walk_idx_q[3:0]}
    : `PARITY_BASE + sec_off + {9'h0, walk_idx_q[3:0]};
  wire [7:0] par_byte = ecc.parity[{~walk_idx_q[3:0], 3'h0} +: 8];
  wire walk_par = walk_on_q & ~walk_data;
  wire walk_wr = walk_par & op_q == nand_seq_pkg::op_prog;
  wire walk_bad = walk_par & op_q == nand_seq_pkg::op_read
    & buf_mem[walk_col] != par_byte;

  assign ecc.valid = walk_on_q & walk_data;
  assign ecc.clear = walk_on_q & walk_idx_q == 10'h0;
  assign ecc.data = buf_mem[walk_col];

  // one write port: parity walk has priority over host data
  wire mem_we = walk_wr | host_wr;
  wire [12:0] mem_addr = walk_wr ? walk_col : col_q;
  wire [7:0] mem_wdata = walk_wr ? par_byte : io_s;
  always_ff @(posedge pclk)
  begin
    if (mem_we)
      buf_mem[mem_addr] <= mem_wdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      walk_on_q <= 1'b0;
      walk_sec_q <= 3'h0;
      walk_idx_q <= 10'h0;
    end
    else if (is_reset || walk_end)
      walk_on_q <= 1'b0;
    else if (go_busy && !start_erase)
    begin
      walk_on_q <= 1'b1;
      walk_sec_q <= 3'h0;
      walk_idx_q <= 10'h0;
    end
    else if (walk_on_q)
    begin
      walk_idx_q <= (walk_idx_q == `WALK_LAST) ? 10'h0 : walk_idx_q + 10'h1;
      if (walk_idx_q == `WALK_LAST)
        walk_sec_q <= walk_sec_q + 3'h1;
    end
  end

  // ****************************************
  // busy timing and results
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_q <= nand_seq_pkg::op_prog;
      timer_q <= '0;
      fail_q <= 2'h0;
      ecc_err_q <= 1'b0;
      ecc_fail_q <= 1'b0;
      read_res_q <= 1'b0;
      cb_ready_q <= 1'b0;
    end
    else
    begin
      if (go_busy)
      begin
        op_q <= start_prog ? nand_seq_pkg::op_prog
          : start_erase ? nand_seq_pkg::op_erase : nand_seq_pkg::op_read;
        timer_q <= start_prog ? prog_time_q : start_erase ? erase_time_q : '0;
        ecc_err_q <= 1'b0;
        read_res_q <= 1'b0;
        cb_ready_q <= 1'b0;
      end
      else if (busy && timer_q != '0)
        timer_q <= timer_q - 1'b1;
      if (walk_bad)
        ecc_err_q <= 1'b1;
      if (is_reset || new_op)
      begin
        fail_q <= 2'h0;
        ecc_fail_q <= 1'b0;
        cb_ready_q <= 1'b0;
      end
      else if (inhibit)
        fail_q <= dist_used_q;
      else if (done && op_q == nand_seq_pkg::op_read)
      begin
        ecc_fail_q <= ecc_err_q;
        read_res_q <= 1'b1;
        cb_ready_q <= 1'b1;
      end
      else if (done)
        fail_q <= fail_inj_q & dist_used_q;
    end
  end

  // ****************************************
  // status output
  // ****************************************
  wire rdy = ~busy;
  wire fail70 = read_res_q ? ecc_fail_q : |fail_q;
  wire [7:0] s70 = {wp_n_s, rdy, rdy, 4'h0, fail70};
  wire [7:0] s71 = {wp_n_s, rdy, rdy, 2'h0, fail_q, |fail_q};
  wire drive = stat_q != nand_seq_pkg::stat_none & ~ce_n_s & ~re_n_s & ~cle_s & ~ale_s;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_q <= nand_seq_pkg::stat_none;
      io_out <= 8'h00;
      io_oe <= 1'b0;
      ready_busy_n <= 1'b1;
    end
    else
    begin
      if (cmd_lat && io_s == `CMD_STAT)
        stat_q <= nand_seq_pkg::stat_70;
      else if (cmd_lat && io_s == `CMD_STAT_DIST)
        stat_q <= nand_seq_pkg::stat_71;
      else if (cmd_lat && (!busy || is_reset))
        stat_q <= nand_seq_pkg::stat_none;
      io_out <= (stat_q == nand_seq_pkg::stat_71) ? s71 : s70;
      io_oe <= drive;
      ready_busy_n <= state_d != nand_seq_pkg::st_busy;
    end
  end

  // ****************************************
  // apb registers
  // ****************************************
  wire hit_prog = paddr == `REG_PROG_TIME;
  wire hit_erase = paddr == `REG_ERASE_TIME;
  wire hit_fail = paddr == `REG_FAIL_INJ;
  wire hit_stat = paddr == `REG_STATUS;
  wire hit = hit_prog | hit_erase | hit_fail | hit_stat;
  wire wr_en = psel & penable & pwrite;
  wire [31:0] rd_mux = hit_prog ? 32'(prog_time_q) : hit_erase ? 32'(erase_time_q)
    : hit_fail ? {30'h0, fail_inj_q}
    : hit_stat ? {27'h0, cb_ready_q, ecc_fail_q, fail_q, busy} : 32'h0;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prog_time_q <= TIME_W'(`PROG_TIME_RST);
      erase_time_q <= TIME_W'(`ERASE_TIME_RST);
      fail_inj_q <= 2'h0;
      prdata <= 32'h0;
    end
    else
    begin
      if (psel && !penable)
        prdata <= rd_mux;
      if (wr_en && hit_prog)
        prog_time_q <= pwdata[TIME_W-1:0];
      if (wr_en && hit_erase)
        erase_time_q <= pwdata[TIME_W-1:0];
      if (wr_en && hit_fail)
        fail_inj_q <= pwdata[1:0];
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  busy_pin_a: assert property (busy |-> !ready_busy_n)
    else $error("busy pin high while busy");
  prog_go_a: assert property (start_prog && wp_n_s
    |=> busy && op_q == nand_seq_pkg::op_prog)
    else $error("program did not start on confirm");
  erase_go_a: assert property (start_erase && wp_n_s |=> busy ##0 !walk_on_q)
    else $error("erase did not start on confirm");
  erase_bare_a: assert property (state_q == nand_seq_pkg::st_idle && cmd_lat
    && io_s == `CMD_ERASE_GO |=> !busy)
    else $error("erase started without setup");
  col_chg_a: assert property (col_chg |=> addr_left_q == 3'h2 ##0
    state_q == nand_seq_pkg::st_load)
    else $error("column change not opened");
  parity_lock_a: assert property (mem_we && !walk_wr |-> mem_addr < `PAGE_BYTES)
    else $error("host wrote parity column");
  walk_len_a: assert property (walk_end |=> !walk_on_q ##1 !walk_on_q)
    else $error("walk overran the page");
  stat71_a: assert property (stat_q == nand_seq_pkg::stat_71 && !busy && !cmd_lat
    |=> io_out[2:0] == {$past(fail_q), |$past(fail_q)} && io_out[6:5] == 2'h3)
    else $error("71h status byte wrong");
  dual_or_a: assert property (stat_q == nand_seq_pkg::stat_70 && !read_res_q
    && |fail_q && !cmd_lat |=> io_out[0])
    else $error("70h fail bit missing");
  ecc_keep_a: assert property (ecc_fail_q && !cmd_lat |=> ecc_fail_q)
    else $error("read result lost");
  district_a: assert property (row_end && !is_reset
    |=> dist_used_q[$past(row_q[`DIST_BIT])])
    else $error("district not recorded");
endmodule

// ===== sim/flash_host.sv
// ****************
// host flash controller model
// ****************
module flash_host (
  // clock
  input wire logic pclk,
  // pins to device
  output logic cle,
  output logic ale,
  output logic ce_n,
  output logic we_n,
  output logic read_strobe_n,
  output logic wp_n,
  output logic [7:0] io_in,
  // pins from device
  input wire logic [7:0] io_out,
  input wire logic io_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    cle = 1'b0;
    ale = 1'b0;
    ce_n = 1'b1;
    we_n = 1'b1;
    read_strobe_n = 1'b1;
    wp_n = 1'b1;
    io_in = 8'h00;
  end

  // one strobe, each level held four edges; bus then shows inverse
  task automatic wr_cyc(input logic c, input logic a, input logic [7:0] d, input logic sel_n = 1'b0);
    @(posedge pclk);
    cle <= c;
    ale <= a;
    ce_n <= sel_n;
    io_in <= d;
    we_n <= 1'b0;
    repeat (4) @(posedge pclk);
    we_n <= 1'b1;
    repeat (4) @(posedge pclk);
    cle <= 1'b0;
    ale <= 1'b0;
    io_in <= ~d;
  endtask

  task automatic set_wp(input logic v);
    @(posedge pclk);
    wp_n <= v;
  endtask

  task automatic cmd(input logic [7:0] c);
    wr_cyc(1'b1, 1'b0, c);
  endtask

  task automatic dat(input logic [7:0] d);
    wr_cyc(1'b0, 1'b0, d);
  endtask

  // n = 5 full, 2 column only, 3 row only
  task automatic addr(input int n, input logic [12:0] col, input logic [16:0] row);
    logic [39:0] b;
    b = {7'h00, row, 3'h0, col};
    for (int i = (n == 3) ? 2 : 0; i < ((n == 2) ? 2 : 5); i++)
      wr_cyc(1'b0, 1'b1, b[8*i +: 8]);
  endtask

  task automatic stat(output logic [7:0] v);
    @(posedge pclk);
    read_strobe_n <= 1'b0;
    repeat (6) @(posedge pclk);
    v = (io_oe === 1'b1) ? io_out : 8'h00;
    read_strobe_n <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
endmodule

// ===== sim/tb_nand_ecc_program_erase_sequencer.sv
module tb_nand_ecc_program_erase_sequencer;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic cle, ale, ce_n, we_n, read_strobe_n, wp_n, io_oe, ready_busy_n;
  logic [1:0] e;
  logic [7:0] io_in, io_out, v;
  int mismatches, cmp_count, cycles;

  nand_seq dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cle(cle), .ale(ale), .ce_n(ce_n), .we_n(we_n),
    .read_strobe_n(read_strobe_n), .wp_n(wp_n), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .ready_busy_n(ready_busy_n));
  flash_host host_u (.pclk(pclk), .cle(cle), .ale(ale), .ce_n(ce_n), .we_n(we_n),
    .read_strobe_n(read_strobe_n), .wp_n(wp_n), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe));

  initial pclk = 1'b0;
  always #25 pclk = ~pclk;

  // ****************
  // shared tasks
  // ****************
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = {pready, pslverr};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic busy_run();
    repeat (2) @(posedge pclk);
    chk(ready_busy_n, 1'b0);
    for (int i = 0; i < 6000 && ready_busy_n !== 1'b1; i++)
      @(posedge pclk);
    chk(ready_busy_n, 1'b1);
  endtask

  task automatic stat_chk(input logic [7:0] c, input logic [7:0] exp);
    host_u.cmd(c);
    host_u.stat(v);
    chk(v, exp);
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_regs();
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(r, 32'h0000_0100);
    chk({30'h0, e}, 32'h0000_0002);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(r, 32'h0000_0400);
    apb(1'b1, 12'h010, 32'h0000_0005);
    chk({30'h0, e}, 32'h0000_0003);
    chk(r, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0008);
    apb(1'b1, 12'h004, 32'h0000_000C);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(r, 32'h0000_000C);
  endtask

  task automatic t_stray_confirm();
    host_u.cmd(8'hD0);
    repeat (4) @(posedge pclk);
    chk(ready_busy_n, 1'b1);
  endtask

  task automatic t_prog();
    apb(1'b1, 12'h008, 32'h0000_0000);
    host_u.cmd(8'h80);
    host_u.addr(5, 13'h0000, 17'h0_0080);
    host_u.dat(8'hA5);
    host_u.cmd(8'h85);
    host_u.addr(2, 13'h1000, 17'h0_0000);
    host_u.dat(8'h3C);
    host_u.cmd(8'h85);
    host_u.addr(2, 13'h1080, 17'h0_0000);
    host_u.dat(8'h5A);
    host_u.cmd(8'h10);
    busy_run();
    stat_chk(8'h70, 8'hE0);
  endtask

  task automatic t_dual_prog();
    apb(1'b1, 12'h008, 32'h0000_0002);
    host_u.cmd(8'h80);
    host_u.addr(5, 13'h0000, 17'h0_0083);
    host_u.dat(8'h11);
    host_u.cmd(8'h11);
    host_u.cmd(8'h70);
    host_u.cmd(8'h81);
    host_u.addr(5, 13'h0000, 17'h0_0043);
    host_u.dat(8'h22);
    host_u.cmd(8'h10);
    busy_run();
    stat_chk(8'h70, 8'hE1);
    stat_chk(8'h71, 8'hE5);
  endtask

  task automatic t_dual_erase();
    apb(1'b1, 12'h008, 32'h0000_0001);
    host_u.cmd(8'h60);
    host_u.addr(3, 13'h0000, 17'h0_0040);
    host_u.cmd(8'h60);
    host_u.addr(3, 13'h0000, 17'h0_0080);
    host_u.cmd(8'hD0);
    busy_run();
    stat_chk(8'h71, 8'hE3);
  endtask

  task automatic t_copy_back();
    apb(1'b1, 12'h008, 32'h0000_0000);
    host_u.cmd(8'h00);
    host_u.addr(5, 13'h0000, 17'h0_0080);
    host_u.cmd(8'h35);
    busy_run();
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk(r & 32'h0000_0019, 32'h0000_0010);
    host_u.cmd(8'h85);
    host_u.addr(5, 13'h0000, 17'h0_0100);
    host_u.dat(8'h77);
    host_u.cmd(8'h85);
    host_u.addr(2, 13'h0400, 17'h0_0000);
    host_u.dat(8'h88);
    host_u.cmd(8'h10);
    busy_run();
    stat_chk(8'h70, 8'hE0);
    host_u.stat(v);
    chk(v, 8'hE0);
  endtask

  task automatic t_protect();
    host_u.cmd(8'h60);
    host_u.addr(3, 13'h0000, 17'h0_0040);
    host_u.wr_cyc(1'b1, 1'b0, 8'hD0, 1'b1);
    repeat (4) @(posedge pclk);
    chk(ready_busy_n, 1'b1);
    host_u.cmd(8'hFF);
    host_u.cmd(8'hD0);
    repeat (4) @(posedge pclk);
    chk(ready_busy_n, 1'b1);
    host_u.set_wp(1'b0);
    host_u.cmd(8'h60);
    host_u.addr(3, 13'h0000, 17'h0_0040);
    host_u.cmd(8'hD0);
    repeat (4) @(posedge pclk);
    chk(ready_busy_n, 1'b1);
    stat_chk(8'h70, 8'h61);
    stat_chk(8'h71, 8'h65);
    host_u.set_wp(1'b1);
    host_u.cmd(8'h80);
    host_u.addr(5, 13'h0000, 17'h0_0080);
    host_u.cmd(8'h10);
    repeat (2) @(posedge pclk);
    chk(ready_busy_n, 1'b0);
    presetn <= 1'b0;
    @(posedge pclk);
    chk({30'h0, io_oe, ready_busy_n}, 32'h0000_0001);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk(r, 32'h0000_0000);
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_stray_confirm();
    t_prog();
    t_dual_prog();
    t_dual_erase();
    t_copy_back();
    t_protect();
    end_of_test();
  end
endmodule
